// ### include/sbp_consts.svh
// constants for the sector/block protection block
`ifndef SBP_CONSTS_SVH
`define SBP_CONSTS_SVH
`define SBP_NUM_GROUPS 128
`define SBP_GRP_W 7
`define SBP_GRP_LSB 18
`define SBP_GRP_MSB 24
`define SBP_ADDR_W 32
`define SBP_LOW_MSB 17
`define SBP_OFS_CTRL 12'h000
`define SBP_OFS_STATUS 12'h004
`define SBP_OFS_CMD 12'h008
`define SBP_OFS_PROT 12'h00C
`define SBP_OFS_PPB 12'h010
`define SBP_OFS_DYB 12'h014
`define SBP_OFS_ACCESS 12'h018
`define SBP_PROG_TIME_US 200
`define SBP_ERASE_TIME_US 30000
`define SBP_CLK_MHZ 20
`define SBP_PROG_CYC (`SBP_PROG_TIME_US * `SBP_CLK_MHZ)
`define SBP_ERASE_CYC (`SBP_ERASE_TIME_US * `SBP_CLK_MHZ)
`define SBP_CNT_W 20
`define SBP_CMD_OP_MSB 3
`define SBP_CMD_BIT 4
`define SBP_CMD_GRP_LSB 8
`define SBP_CMD_GRP_MSB 14
`define SBP_OP_NONE 4'h0
`define SBP_OP_PPB_PROG 4'h1
`define SBP_OP_PPB_ERASE 4'h2
`define SBP_OP_LOCK_CLR 4'h3
`define SBP_OP_UNLOCK 4'h4
`define SBP_OP_DYB_WR 4'h5
`define SBP_OP_SW_RESET 4'h6
`define SBP_ST_BUSY 0
`define SBP_ST_LOCK 1
`define SBP_ST_PERR 2
`define SBP_ST_EERR 3
`define SBP_ST_ARRAY_OK 4
`define SBP_ST_MODE 5
`endif

// ### include/sbp_pkg.sv
// types for the sector/block protection block
package sbp_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sbp_apb_req_type;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sbp_apb_rsp_type;
  typedef enum logic [1:0] {
    SBP_IDLE = 2'b00,
    SBP_PROG = 2'b01,
    SBP_ERASE = 2'b10
  } sbp_state_type;
endpackage

// ### src/sbp_op_timer.sv
// down counter that times one persistent-bit operation
`timescale 1ns/1ps
`include "sbp_consts.svh"
module sbp_op_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // control
  input wire logic start,
  input wire logic [`SBP_CNT_W-1:0] loadVal,
  // status
  output logic done
);
  logic [`SBP_CNT_W-1:0] cnt_q;
  logic run_q;
  assign done = run_q && (cnt_q == '0);
  // loads on start, counts to zero, then reports done for one cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (start) begin
      cnt_q <= loadVal;
      run_q <= 1'b1;
    end else if (done) begin
      run_q <= 1'b0;
    end else if (run_q) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// ### src/sbp_protect.sv
// sector/block protection bits with apb register access
// Overview of operation
// RULE1 - one retained persistent bit per block
// RULE2 - program clears one bit, erase sets all
// RULE3 - no single erase, erase needs no address
// RULE4 - lock cleared rejects persistent program and erase
// RULE5 - volatile lock guards all persistent bits together
// RULE6 - persistent mode: reset sets lock
// RULE7 - persistent mode: no command sets lock again
// RULE8 - password mode: reset clears lock
// RULE9 - password mode: only unlock success sets lock
// RULE10 - one volatile dynamic bit per block
// RULE11 - dynamic write: 0 protects, 1 unprotects
// RULE12 - dynamic bit matters only if persistent erased
// RULE13 - no array reads while programming persistent
// RULE14 - host reads persistent bit at block start
// RULE15 - status shows progress for host polling
// RULE16 - program page time, erase sector time
// RULE17 - host clears lock after configuring bits
// RULE18 - group n covers 256KB block n
// RULE19 - factory state has all persistent bits one
// RULE20 - resets leave dynamic bits unprotected
// RULE21 - software reset keeps lock unchanged
// RULE22 - protected unless both bits one; refuse writes
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
`include "sbp_consts.svh"
module sbp_protect (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // apb slave
  input wire sbp_pkg::sbp_apb_req_type apbReq,
  output sbp_pkg::sbp_apb_rsp_type apbRsp,
  // protection mode strap: 1 password mode, 0 persistent mode
  input wire logic passwordMode,
  // password compare result from the password datapath
  input wire logic unlockMatch,
  // persistent bit image kept by the non-volatile store
  input wire logic [`SBP_NUM_GROUPS-1:0] nvPpbIn,
  output logic [`SBP_NUM_GROUPS-1:0] nvPpbOut,
  output logic nvPpbWrite,
  // array access check
  input wire logic [`SBP_ADDR_W-1:0] accessAddr,
  output logic accessProtected,
  output logic arrayReadBlock
);
  import sbp_pkg::*;

  logic modeS1_q, modeS2_q, matchS1_q, matchS2_q;
  logic wake1_q, wake2_q;
  logic [`SBP_NUM_GROUPS-1:0] ppb_q, ppb_d;
  logic [`SBP_NUM_GROUPS-1:0] dyb_q, dyb_d;
  logic lock_q, lock_d;
  logic loaded_q;
  logic perr_q, perr_d, eerr_q, eerr_d;
  logic [`SBP_GRP_W-1:0] grp_q, grp_d;
  logic [`SBP_GRP_W-1:0] sel_q;
  logic [31:0] rdata_q;
  sbp_state_type state_q, state_d;
  logic timerStart, timerDone;
  logic [`SBP_CNT_W-1:0] timerLoad;

  // strap and compare result come from outside, so synchronise them;
  // the wake pair marks when the strap has passed both flops
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      modeS1_q <= 1'b0;
      modeS2_q <= 1'b0;
      matchS1_q <= 1'b0;
      matchS2_q <= 1'b0;
      wake1_q <= 1'b0;
      wake2_q <= 1'b0;
    end else begin
      modeS1_q <= passwordMode;
      modeS2_q <= modeS1_q;
      matchS1_q <= unlockMatch;
      matchS2_q <= matchS1_q;
      wake1_q <= 1'b1;
      wake2_q <= wake1_q;
    end
  end

  // apb decode
  wire apbAccess = apbReq.psel && apbReq.penable;
  wire apbWr = apbAccess && apbReq.pwrite;
  wire apbRd = apbAccess && !apbReq.pwrite;
  wire [11:0] ofs = apbReq.paddr;
  wire hitCtrl = (ofs == `SBP_OFS_CTRL);
  wire hitStat = (ofs == `SBP_OFS_STATUS);
  wire hitCmd = (ofs == `SBP_OFS_CMD);
  wire hitProt = (ofs == `SBP_OFS_PROT);
  wire hitPpb = (ofs == `SBP_OFS_PPB);
  wire hitDyb = (ofs == `SBP_OFS_DYB);
  wire hitAcc = (ofs == `SBP_OFS_ACCESS);
  wire mapped = hitCtrl | hitStat | hitCmd | hitProt | hitPpb | hitDyb
                | hitAcc;
  wire busy = (state_q != SBP_IDLE);

  // command word: op in [3:0], data bit in [4], group in [14:8]
  wire cmdWr = apbWr && hitCmd;
  wire [3:0] cmdOp = apbReq.pwdata[`SBP_CMD_OP_MSB:0];
  wire cmdBit = apbReq.pwdata[`SBP_CMD_BIT];
  wire [`SBP_GRP_W-1:0] cmdGrp =
    apbReq.pwdata[`SBP_CMD_GRP_MSB:`SBP_CMD_GRP_LSB];
  wire isProg = cmdWr && (cmdOp == `SBP_OP_PPB_PROG);
  wire isErase = cmdWr && (cmdOp == `SBP_OP_PPB_ERASE);
  wire isLockClr = cmdWr && (cmdOp == `SBP_OP_LOCK_CLR);
  wire isUnlock = cmdWr && (cmdOp == `SBP_OP_UNLOCK);
  wire isDybWr = cmdWr && (cmdOp == `SBP_OP_DYB_WR);
  wire isSwRst = cmdWr && (cmdOp == `SBP_OP_SW_RESET);
  wire ppbOk = lock_q && !busy && loaded_q; // [RULE4] [RULE5]

  // group of a byte address: bits 24..18 select a 256KB block
  wire [`SBP_GRP_W-1:0] accGrp =
    accessAddr[`SBP_GRP_MSB:`SBP_GRP_LSB]; // [RULE18]
  wire accUnprot = ppb_q[accGrp] && dyb_q[accGrp]; // [RULE12] [RULE22]
  assign accessProtected = !accUnprot; // [RULE22]
  assign arrayReadBlock = (state_q == SBP_PROG); // [RULE13]
  assign nvPpbOut = ppb_q; // [RULE1]
  assign nvPpbWrite = timerDone;

  assign timerStart = (isProg || isErase) && ppbOk;
  assign timerLoad = isErase ? `SBP_CNT_W'(`SBP_ERASE_CYC)
                             : `SBP_CNT_W'(`SBP_PROG_CYC); // [RULE16]

  sbp_op_timer uTimer (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(timerStart),
    .loadVal(timerLoad),
    .done(timerDone)
  );

  // operation sequencing and bit updates
  always_comb begin
    state_d = state_q;
    ppb_d = ppb_q;
    dyb_d = dyb_q;
    lock_d = lock_q;
    perr_d = perr_q;
    eerr_d = eerr_q;
    grp_d = grp_q;
    case (state_q)
      SBP_IDLE: begin
        if (isProg) begin
          if (ppbOk) begin
            state_d = SBP_PROG;
            grp_d = cmdGrp;
            perr_d = 1'b0;
          end else begin
            perr_d = 1'b1; // [RULE4]
          end
        end else if (isErase) begin
          if (ppbOk) begin
            state_d = SBP_ERASE; // [RULE3]
            eerr_d = 1'b0;
          end else begin
            eerr_d = 1'b1; // [RULE4]
          end
        end
      end
      SBP_PROG: begin
        if (timerDone) begin
          ppb_d[grp_q] = 1'b0; // [RULE2]
          state_d = SBP_IDLE;
        end
      end
      SBP_ERASE: begin
        if (timerDone) begin
          ppb_d = '1; // [RULE2] [RULE3]
          state_d = SBP_IDLE;
        end
      end
      default: state_d = SBP_IDLE;
    endcase
    // lock clears by command or hardware reset; in password mode a match sets it
    if (isLockClr) begin
      lock_d = 1'b0; // [RULE7]
    end else if (isUnlock && modeS2_q && matchS2_q) begin
      lock_d = 1'b1; // [RULE9]
    end else if (isUnlock) begin
      perr_d = 1'b1;
    end
    if (isDybWr) begin
      dyb_d[cmdGrp] = cmdBit; // [RULE10] [RULE11]
    end
    if (isSwRst) begin
      dyb_d = '1; // [RULE20] [RULE21]
    end
    // a retained image is copied on each of the first three edges after reset, not under reset;
    // lock waits for a settled strap so password mode never opens early
    if (!loaded_q) begin
      ppb_d = nvPpbIn; // [RULE1]
      lock_d = wake2_q && !modeS2_q; // [RULE6] [RULE8]
    end
  end

  // protection state; dynamic bits come up unprotected
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= SBP_IDLE;
      ppb_q <= '1; // [RULE19]
      dyb_q <= '1; // [RULE20]
      lock_q <= 1'b0;
      perr_q <= 1'b0;
      eerr_q <= 1'b0;
      grp_q <= '0;
      loaded_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ppb_q <= ppb_d;
      dyb_q <= dyb_d;
      lock_q <= lock_d;
      perr_q <= perr_d;
      eerr_q <= eerr_d;
      grp_q <= grp_d;
      loaded_q <= loaded_q | wake2_q;
    end
  end

  // select register picks the group for bit readback
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sel_q <= '0;
    end else if (apbWr && hitCtrl) begin
      sel_q <= apbReq.pwdata[`SBP_GRP_W-1:0];
    end
  end

  // status word lets the host poll progress
  wire [31:0] statWord = {26'h0, modeS2_q, !arrayReadBlock,
                          eerr_q, perr_q, lock_q, busy}; // [RULE15]
  wire [31:0] rdMux =
    hitCtrl ? {25'h0, sel_q} :
    hitStat ? statWord :
    hitPpb ? {31'h0, ppb_q[sel_q]} :
    hitDyb ? {31'h0, dyb_q[sel_q]} :
    hitAcc ? {31'h0, accessProtected} :
    32'h00000000;

  // read data is registered; answer comes in the first access cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 32'h00000000;
    end else if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
      rdata_q <= rdMux;
    end
  end

  assign apbRsp.pready = 1'b1;
  assign apbRsp.pslverr = apbAccess && !mapped;
  assign apbRsp.prdata = apbRd ? rdata_q : 32'h00000000;
endmodule

// ### dv/sbp_protect_chk_sva.sv
// port assertions for the protection block
`timescale 1ns/1ps
`include "sbp_consts.svh"
module sbp_protect_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // apb
  input wire sbp_pkg::sbp_apb_req_type apbReq,
  input wire sbp_pkg::sbp_apb_rsp_type apbRsp,
  // straps and store
  input wire logic passwordMode,
  input wire logic unlockMatch,
  input wire logic [`SBP_NUM_GROUPS-1:0] nvPpbIn,
  input wire logic [`SBP_NUM_GROUPS-1:0] nvPpbOut,
  input wire logic nvPpbWrite,
  // array check
  input wire logic [`SBP_ADDR_W-1:0] accessAddr,
  input wire logic accessProtected,
  input wire logic arrayReadBlock
);
  import sbp_pkg::*;
  localparam int ProgLo = `SBP_PROG_CYC - 4;
  localparam int ProgHi = `SBP_PROG_CYC + 4;
  logic [15:0] busyCnt_q;
  // decoded views of the bus and the checked block
  wire [6:0] grp = accessAddr[`SBP_GRP_MSB:`SBP_GRP_LSB];
  wire acc = apbReq.psel && apbReq.penable;
  wire stRead = acc && !apbReq.pwrite && apbReq.paddr == `SBP_OFS_STATUS;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // length of the blocked window, since ranges cannot reach 4000
  always_ff @(posedge ref_clk or posedge reset)
    if (reset) busyCnt_q <= '0;
    else busyCnt_q <= arrayReadBlock ? busyCnt_q + 16'h1 : '0;
  sequence dybWrite;
    acc && apbReq.pwrite && apbReq.paddr == `SBP_OFS_CMD &&
    apbReq.pwdata[3:0] == `SBP_OP_DYB_WR && apbReq.pwdata[14:8] == grp;
  endsequence
  chk_read_blocked: assert property ($rose(arrayReadBlock) |->
    arrayReadBlock[*8]) else $error("array reads reopened early");
  chk_busy_shown: assert property (stRead &&
    $past(arrayReadBlock) && arrayReadBlock |->
    apbRsp.prdata[`SBP_ST_BUSY] &&
    !apbRsp.prdata[`SBP_ST_ARRAY_OK]) else $error("busy not reported");
  chk_prog_time: assert property ($fell(arrayReadBlock) |->
    busyCnt_q inside {[ProgLo:ProgHi]}) else $error("program time off");
  chk_store_pulse: assert property (nvPpbWrite |=> !nvPpbWrite)
    else $error("store pulse too long");
  chk_ppb_protects: assert property (!nvPpbOut[grp] |->
    accessProtected) else $error("programmed block left open");
  chk_group_map: assert property ($stable(grp) &&
    $stable(nvPpbOut) && !$past(acc && apbReq.pwrite) |->
    $stable(accessProtected))
    else $error("protection changed inside one block");
  chk_prog_one_bit: assert property ($changed(nvPpbOut) &&
    $past(arrayReadBlock) |-> $countones(nvPpbOut ^ $past(nvPpbOut)) == 1
    && (nvPpbOut & ~$past(nvPpbOut)) == '0) else $error("program hit more");
  chk_dyb_sets: assert property (dybWrite |=>
    ($stable(grp) && nvPpbOut[grp]) |->
    accessProtected == !$past(apbReq.pwdata[4])) else $error("dynamic bit");
endmodule
bind sbp_protect sbp_protect_chk chk (.*);

// ### dv/sbp_host_model.sv
// host-side model issuing apb protection commands
`timescale 1ns/1ps
`include "sbp_consts.svh"
module sbp_host_model (
  // clock
  input wire logic ref_clk,
  // apb master
  output sbp_pkg::sbp_apb_req_type apbReq,
  input wire sbp_pkg::sbp_apb_rsp_type apbRsp,
  // array address to check
  output logic [`SBP_ADDR_W-1:0] accessAddr
);
  import sbp_pkg::*;
  // error flag of the last completed transfer
  logic lastErr;
  initial begin
    apbReq = '0;
    accessAddr = '0;
    lastErr = 1'b0;
  end
  // one transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    do @(posedge ref_clk); while (apbRsp.pready !== 1'b1);
    q = apbRsp.prdata;
    lastErr = apbRsp.pslverr;
    apbReq <= '0;
    @(posedge ref_clk);
  endtask
  // byte zero of the block, unused high bits zero
  task automatic aim(input logic [6:0] g);
    accessAddr <= {7'h00, g, 18'h00000};
  endtask
endmodule

// ### dv/test_sector_block_protection_bits.sv
// testbench for the protection block
`timescale 1ns/1ps
`include "sbp_consts.svh"
module test_sector_block_protection_bits;
  import sbp_pkg::*;
  logic ref_clk, reset, passwordMode, unlockMatch, accessProtected;
  logic arrayReadBlock, nvPpbWrite;
  logic [127:0] nvPpbIn, nvPpbOut;
  logic [31:0] accessAddr, q;
  sbp_apb_req_type apbReq;
  sbp_apb_rsp_type apbRsp;
  int n_mismatch = 0;
  int n_checks = 0;
  logic storeDue;
  // the store keeps the image that follows each completion pulse, so a
  // hardware reset reloads what was programmed before it
  always @(posedge ref_clk) begin
    storeDue <= nvPpbWrite;
    if (storeDue) begin
      nvPpbIn <= nvPpbOut;
    end
  end
  // rows: group, dynamic bit written, expected protection
  logic [8:0] rows [5] = '{9'h001, 9'h002, 9'h1FD, 9'h005, 9'h00B};
  sbp_protect dut (.ref_clk(ref_clk), .reset(reset), .apbReq(apbReq),
    .apbRsp(apbRsp), .passwordMode(passwordMode),
    .unlockMatch(unlockMatch), .nvPpbIn(nvPpbIn), .nvPpbOut(nvPpbOut),
    .nvPpbWrite(nvPpbWrite), .accessAddr(accessAddr),
    .accessProtected(accessProtected), .arrayReadBlock(arrayReadBlock));
  sbp_host_model host (.ref_clk(ref_clk), .apbReq(apbReq),
    .apbRsp(apbRsp), .accessAddr(accessAddr));
  task automatic check(input string what, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [6:0] g, logic b);
    host.xfer(1'b1, `SBP_OFS_CMD, {17'h0, g, 3'h0, b, op}, q);
  endtask
  // select a group, then read one of its bits back
  task automatic rd_bit(input logic [6:0] g, input logic [11:0] a);
    host.xfer(1'b1, `SBP_OFS_CTRL, {25'h0, g}, q);
    rd(a);
  endtask
  task automatic hw_reset(input logic pw);
    passwordMode <= pw;
    reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // a hang ends the run well past the expected span
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    stop_test;
  end
  initial begin
    reset = 1'b1;
    passwordMode = 1'b0;
    unlockMatch = 1'b0;
    nvPpbIn = ~128'h4; // group 2 already programmed in the store
    hw_reset(1'b0);
    rd(`SBP_OFS_STATUS);
    check("lock", q[`SBP_ST_LOCK], 1);
    check("okay", host.lastErr, 0);
    foreach (rows[i]) begin
      host.aim(rows[i][8:2]);
      cmd(`SBP_OP_DYB_WR, rows[i][8:2], rows[i][1]);
      check("protected", accessProtected, rows[i][0]);
    end
    // second program while busy must be turned away
    cmd(`SBP_OP_PPB_PROG, 7'h05, 1'b0);
    cmd(`SBP_OP_PPB_PROG, 7'h09, 1'b0);
    rd(`SBP_OFS_STATUS);
    check("busy", q[`SBP_ST_BUSY], 1);
    check("readable", q[`SBP_ST_ARRAY_OK], 0);
    // a request while busy is ignored and leaves the error flag alone
    check("perr", q[`SBP_ST_PERR], 0);
    do rd(`SBP_OFS_STATUS); while (q[0] !== 1'b0 && n_checks < 9000);
    rd_bit(7'h05, `SBP_OFS_PPB);
    check("ppb5", q[0], 0);
    rd_bit(7'h09, `SBP_OFS_PPB);
    check("ppb9", q[0], 1);
    rd_bit(7'h02, `SBP_OFS_PPB);
    check("ppb2", q[0], 0);
    host.aim(7'h05);
    rd(`SBP_OFS_ACCESS);
    check("access5", q[0], 1);
    cmd(`SBP_OP_LOCK_CLR, 7'h00, 1'b0);
    cmd(`SBP_OP_PPB_ERASE, 7'h00, 1'b0);
    unlockMatch <= 1'b1;
    rd(`SBP_OFS_STATUS);
    check("eerr", q[`SBP_ST_EERR], 1);
    check("idle", q[`SBP_ST_BUSY], 0);
    rd_bit(7'h05, `SBP_OFS_PPB);
    check("kept", q[0], 0);
    cmd(`SBP_OP_UNLOCK, 7'h00, 1'b0);
    cmd(`SBP_OP_SW_RESET, 7'h00, 1'b0);
    rd(`SBP_OFS_STATUS);
    check("relock", q[`SBP_ST_LOCK], 0);
    rd_bit(7'h01, `SBP_OFS_DYB);
    check("dyb1", q[0], 1);
    unlockMatch <= 1'b0;
    hw_reset(1'b1);
    rd_bit(7'h05, `SBP_OFS_PPB);
    check("ppb5kept", q[0], 0);
    rd(`SBP_OFS_STATUS);
    check("pwlock", q[`SBP_ST_LOCK], 0);
    cmd(`SBP_OP_UNLOCK, 7'h00, 1'b0);
    rd(`SBP_OFS_STATUS);
    check("badpw", q[`SBP_ST_LOCK], 0);
    unlockMatch <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cmd(`SBP_OP_UNLOCK, 7'h00, 1'b0);
    rd(`SBP_OFS_STATUS);
    check("goodpw", q[`SBP_ST_LOCK], 1);
    rd(12'h01C);
    check("slverr", host.lastErr, 1);
    stop_test;
  end
endmodule
